// ===== frs_defs.svh
// constants for the fdc result status registers
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH

// ----------------------------------------------------------------
// result byte order
// ----------------------------------------------------------------
`define FRS_IDX_ST0        2'h0
`define FRS_IDX_ST1        2'h1
`define FRS_IDX_ST2        2'h2
`define FRS_IDX_ST3        2'h3
`define FRS_IDX_LAST       2'h3

// ----------------------------------------------------------------
// termination codes, reset values and bad cylinder id
// ----------------------------------------------------------------
`define FRS_TERM_NORMAL    2'h0
`define FRS_TERM_ABNORMAL  2'h1
`define FRS_TERM_INVALID   2'h2
`define FRS_RST_BYTE       8'h00
`define FRS_RST_CYL        8'h00
`define FRS_BAD_CYL        8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FRS_RECAL_STEPS    7'h4D
`define FRS_CLK_PERIOD_NS  8
`define FRS_SVC_WINDOW_NS  12000
`define FRS_SVC_CYCLES     ((`FRS_SVC_WINDOW_NS) / (`FRS_CLK_PERIOD_NS))

`endif

// ===== frs_pkg.sv
// types for the fdc result status registers
package frs_pkg;

   // ----------------------------------------------------------------
   // phases
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {FRS_IDLE, FRS_EXEC, FRS_RESULT} frs_phase_t;

   // ----------------------------------------------------------------
   // command description, held from start
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       is_write;
      logic       is_read_scan;
      logic       is_scan;
      logic       is_recal;
      logic [7:0] cyl;
   } frs_cmd_t;

   // ----------------------------------------------------------------
   // one-cycle events from the controller core
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       seek_done;
      logic       beyond_last;
      logic       crc_id;
      logic       crc_data;
      logic       sector_absent;
      logic       readid_fail;
      logic       track_start_absent;
      logic       id_mark_absent;
      logic       data_mark_absent;
      logic       deleted_mark;
      logic       scan_equal;
      logic       scan_none;
      logic       id_seen;
      logic [7:0] id_cyl;
      logic       step_pulse;
      logic       byte_req;
      logic       byte_taken;
   } frs_evt_t;

   // ----------------------------------------------------------------
   // drive sense and select levels
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       write_prot;
      logic       track_zero;
      logic       side_sel;
      logic [1:0] unit_sel;
   } frs_drive_t;

endpackage

// ===== frs_status.sv
// result status registers of the floppy controller
`timescale 1ns/1ns
`include "frs_defs.svh"

module frs_status
#(
   parameter int SVC_CYCLES = `FRS_SVC_CYCLES
)
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   // command sequencing from the core
   input  wire logic               cmd_start,
   input  wire frs_pkg::frs_cmd_t  cmd_info,
   input  wire logic               cmd_done,
   input  wire logic [1:0]         cmd_term,
   input  wire logic               head_sel,
   // execution events
   input  wire frs_pkg::frs_evt_t  evt,
   // drive levels
   input  wire frs_pkg::frs_drive_t drive,
   // data register read
   input  wire logic               data_rd,
   output logic [7:0]              rd_data_r,
   output logic                    result_avail_r,
   output logic                    exec_busy_r
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   frs_pkg::frs_phase_t phase_r;
   frs_pkg::frs_phase_t phase_nxt;
   frs_pkg::frs_cmd_t   cmd_r;
   logic [1:0]          ptr_r;
   logic [1:0]          ptr_nxt;
   logic [1:0]          termination_code_r;
   logic                positioning_done_r;
   logic                track_zero_fault_r;
   logic                head_at_interrupt_r;
   logic                drive_number_high_r;
   logic                drive_number_low_r;
   logic                end_of_cyl_r;
   logic                crc_fault_any_field_r;
   logic                overrun_r;
   logic                sector_missing_r;
   logic                write_blocked_r;
   logic                id_sync_absent_r;
   logic                deleted_sector_hit_r;
   logic                crc_fault_payload_r;
   logic                cylinder_mismatch_r;
   logic                scan_equal_hit_r;
   logic                scan_unmet_r;
   logic                bad_track_ff_r;
   logic                payload_sync_absent_r;
   logic [7:0]          target_id_store_r;
   logic [7:0]          sense_r;
   logic [6:0]          step_cnt_r;
   logic [6:0]          step_cnt_nxt;
   logic [15:0]         svc_cnt_r;
   logic                svc_pend_r;
   logic                in_exec;
   logic                clr;
   logic                mismatch;
   logic                fault_set;
   logic                ovr_set;

   // ----------------------------------------------------------------
   // sticky flag update, set wins over clear
   // ----------------------------------------------------------------
   function automatic logic upd(input logic q, input logic c, input logic s);
      upd = (q & ~c) | s;
   endfunction

   assign in_exec  = (phase_r == frs_pkg::FRS_EXEC);
   assign clr      = cmd_start;
   assign mismatch = in_exec & evt.id_seen & (evt.id_cyl != target_id_store_r);

   // ----------------------------------------------------------------
   // phase sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      phase_nxt = phase_r;
      ptr_nxt   = ptr_r;
      case (phase_r)
         frs_pkg::FRS_IDLE:
         begin
            if (cmd_start)
               phase_nxt = frs_pkg::FRS_EXEC;
         end
         frs_pkg::FRS_EXEC:
         begin
            if (cmd_done)
               phase_nxt = frs_pkg::FRS_RESULT;
         end
         frs_pkg::FRS_RESULT:
         begin
            if (data_rd)
            begin
               ptr_nxt = ptr_r + 2'h1;
               if (ptr_r == `FRS_IDX_LAST)
                  phase_nxt = frs_pkg::FRS_IDLE;
            end
         end
         default:
            phase_nxt = frs_pkg::FRS_IDLE;
      endcase
      if (cmd_done && phase_r == frs_pkg::FRS_IDLE)
         phase_nxt = frs_pkg::FRS_RESULT;
      if (phase_nxt != frs_pkg::FRS_RESULT || phase_r != frs_pkg::FRS_RESULT)
         ptr_nxt = `FRS_IDX_ST0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         phase_r        <= frs_pkg::FRS_IDLE;
         ptr_r          <= `FRS_IDX_ST0;
         result_avail_r <= 1'b0;
         exec_busy_r    <= 1'b0;
      end
      else
      begin
         phase_r        <= phase_nxt;
         ptr_r          <= ptr_nxt;
         result_avail_r <= (phase_nxt == frs_pkg::FRS_RESULT);
         exec_busy_r    <= (phase_nxt == frs_pkg::FRS_EXEC);
      end
   end

   // ----------------------------------------------------------------
   // command capture and completion code
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         cmd_r             <= '0;
         target_id_store_r <= `FRS_RST_CYL;
      end
      else if (cmd_start)
      begin
         cmd_r             <= cmd_info;
         target_id_store_r <= cmd_info.cyl;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         termination_code_r  <= `FRS_TERM_NORMAL;
         head_at_interrupt_r <= 1'b0;
         drive_number_high_r <= 1'b0;
         drive_number_low_r  <= 1'b0;
      end
      else if (cmd_done)
      begin
         termination_code_r  <= cmd_term;
         head_at_interrupt_r <= head_sel;
         drive_number_high_r <= drive.unit_sel[1];
         drive_number_low_r  <= drive.unit_sel[0];
      end
   end

   // ----------------------------------------------------------------
   // recalibrate step counting
   // ----------------------------------------------------------------
   assign step_cnt_nxt = step_cnt_r + 7'h01;
   assign fault_set    = in_exec & cmd_r.is_recal & evt.step_pulse & ~drive.track_zero
                         & (step_cnt_nxt == `FRS_RECAL_STEPS);

   always_ff @(posedge sys_clk)
   begin
      if (!resetn || clr)
         step_cnt_r <= 7'h00;
      else if (in_exec && cmd_r.is_recal && evt.step_pulse
               && step_cnt_r != `FRS_RECAL_STEPS)
         step_cnt_r <= step_cnt_nxt;
   end

   // ----------------------------------------------------------------
   // host service window for data bytes
   // ----------------------------------------------------------------
   assign ovr_set = in_exec & svc_pend_r & ~evt.byte_taken & (svc_cnt_r == 16'h0001);

   always_ff @(posedge sys_clk)
   begin
      if (!resetn || clr)
      begin
         svc_pend_r <= 1'b0;
         svc_cnt_r  <= 16'h0000;
      end
      else if (evt.byte_req && in_exec)
      begin
         svc_pend_r <= 1'b1;
         svc_cnt_r  <= 16'(SVC_CYCLES);
      end
      else if (evt.byte_taken || ovr_set)
         svc_pend_r <= 1'b0;
      else if (svc_pend_r)
         svc_cnt_r <= svc_cnt_r - 16'h0001;
   end

   // ----------------------------------------------------------------
   // first byte flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         positioning_done_r <= 1'b0;
         track_zero_fault_r <= 1'b0;
      end
      else
      begin
         positioning_done_r <= upd(positioning_done_r, clr,
                                   in_exec & evt.seek_done);
         track_zero_fault_r <= upd(track_zero_fault_r, clr, fault_set);
      end
   end

   // ----------------------------------------------------------------
   // second byte flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         end_of_cyl_r          <= 1'b0;
         crc_fault_any_field_r <= 1'b0;
         overrun_r             <= 1'b0;
         sector_missing_r      <= 1'b0;
         write_blocked_r       <= 1'b0;
         id_sync_absent_r      <= 1'b0;
      end
      else
      begin
         end_of_cyl_r          <= upd(end_of_cyl_r, clr, in_exec & evt.beyond_last);
         crc_fault_any_field_r <= upd(crc_fault_any_field_r, clr,
                                      in_exec & (evt.crc_id | evt.crc_data));
         overrun_r             <= upd(overrun_r, clr, ovr_set);
         sector_missing_r      <= upd(sector_missing_r, clr, in_exec
                                      & (evt.sector_absent | evt.readid_fail
                                      | evt.track_start_absent | mismatch));
         write_blocked_r       <= upd(write_blocked_r, clr,
                                      in_exec & cmd_r.is_write & drive.write_prot);
         id_sync_absent_r      <= upd(id_sync_absent_r, clr, in_exec
                                      & (evt.id_mark_absent | evt.data_mark_absent));
      end
   end

   // ----------------------------------------------------------------
   // third byte flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         deleted_sector_hit_r  <= 1'b0;
         crc_fault_payload_r   <= 1'b0;
         cylinder_mismatch_r   <= 1'b0;
         scan_equal_hit_r      <= 1'b0;
         scan_unmet_r          <= 1'b0;
         bad_track_ff_r        <= 1'b0;
         payload_sync_absent_r <= 1'b0;
      end
      else
      begin
         deleted_sector_hit_r  <= upd(deleted_sector_hit_r, clr,
                                      in_exec & cmd_r.is_read_scan & evt.deleted_mark);
         crc_fault_payload_r   <= upd(crc_fault_payload_r, clr, in_exec & evt.crc_data);
         cylinder_mismatch_r   <= upd(cylinder_mismatch_r, clr, mismatch);
         scan_equal_hit_r      <= upd(scan_equal_hit_r, clr,
                                      in_exec & cmd_r.is_scan & evt.scan_equal);
         scan_unmet_r          <= upd(scan_unmet_r, clr,
                                      in_exec & cmd_r.is_scan & evt.scan_none);
         bad_track_ff_r        <= upd(bad_track_ff_r, clr,
                                      mismatch & (evt.id_cyl == `FRS_BAD_CYL));
         payload_sync_absent_r <= upd(payload_sync_absent_r, clr,
                                      in_exec & evt.data_mark_absent);
      end
   end

   // ----------------------------------------------------------------
   // live drive sense byte
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         sense_r <= `FRS_RST_BYTE;
      else
         sense_r <= {1'b0, drive.write_prot, 1'b1, drive.track_zero,
                     drive.write_prot, drive.side_sel, drive.unit_sel};
   end

   // ----------------------------------------------------------------
   // result byte selection
   // ----------------------------------------------------------------
   function automatic logic [7:0] pick(input logic [1:0] idx);
      case (idx)
         `FRS_IDX_ST0: pick = {termination_code_r, positioning_done_r, track_zero_fault_r,
                               1'b0, head_at_interrupt_r, drive_number_high_r,
                               drive_number_low_r};
         `FRS_IDX_ST1: pick = {end_of_cyl_r, 1'b0, crc_fault_any_field_r, overrun_r,
                               1'b0, sector_missing_r, write_blocked_r,
                               id_sync_absent_r};
         `FRS_IDX_ST2: pick = {1'b0, deleted_sector_hit_r, crc_fault_payload_r,
                               cylinder_mismatch_r, scan_equal_hit_r, scan_unmet_r,
                               bad_track_ff_r, payload_sync_absent_r};
         default:      pick = sense_r;
      endcase
   endfunction

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         rd_data_r <= `FRS_RST_BYTE;
      // completion byte shows the values taken with the interrupt, not the stale ones
      else if (cmd_done && ptr_nxt == `FRS_IDX_ST0)
         rd_data_r <= {cmd_term, upd(positioning_done_r, clr, in_exec & evt.seek_done),
                       upd(track_zero_fault_r, clr, fault_set), 1'b0, head_sel,
                       drive.unit_sel};
      else
         rd_data_r <= pick(ptr_nxt);
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   not_ready_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ptr_r == `FRS_IDX_ST0 && $past(ptr_r) == `FRS_IDX_ST0) |-> !rd_data_r[3])
      else $error("not ready bit seen high");

   st1_spare_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ptr_r == `FRS_IDX_ST1) |=> ($past(ptr_nxt) != `FRS_IDX_ST1 || rd_data_r[6:6] == 1'b0
                                   && rd_data_r[3] == 1'b0))
      else $error("spare bits of second byte high");

   sense_fixed_bits_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $past(resetn) |-> (sense_r[7:5] == {1'b0, $past(drive.write_prot), 1'b1}))
      else $error("sense byte fixed bits wrong");

   sense_wp_dup_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $past(resetn) |-> (sense_r[3] == $past(drive.write_prot)
                         && sense_r[4] == $past(drive.track_zero)))
      else $error("write protect copies differ");

   seek_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (in_exec && evt.seek_done) |=> positioning_done_r)
      else $error("seek end not flagged");

   recal_fault_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (track_zero_fault_r && !$past(track_zero_fault_r)) |->
      ($past(step_cnt_r) == 7'h4C && $past(evt.step_pulse) && !$past(drive.track_zero)))
      else $error("track zero fault at wrong step");

   flags_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (cmd_start && !evt.beyond_last && !evt.crc_data && !evt.crc_id) |=>
      (!end_of_cyl_r && !crc_fault_payload_r && !crc_fault_any_field_r))
      else $error("flags not cleared at command start");

   bad_cyl_pair_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (mismatch && evt.id_cyl == 8'hFF) |=> (bad_track_ff_r && cylinder_mismatch_r
                                             && sector_missing_r))
      else $error("bad cylinder not flagged");

   missing_mark_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (in_exec && evt.data_mark_absent) |=> (id_sync_absent_r && payload_sync_absent_r))
      else $error("missing data mark not flagged twice");

   result_order_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (phase_r == frs_pkg::FRS_RESULT && data_rd && ptr_r != `FRS_IDX_LAST && !cmd_done)
      |=> (ptr_r == $past(ptr_r) + 2'h1))
      else $error("result pointer did not advance");

endmodule

// ===== frs_drive_model.sv
// disk drive sense model for the result status bench
`timescale 1ns/1ns
module frs_drive_model
(
   // clock and reset
   input  wire logic           sys_clk,
   input  wire logic           resetn,
   // step pulses from the core and bench controls
   input  wire logic           step,
   input  wire logic [6:0]     home_at,
   input  wire logic           wp_in,
   input  wire logic           side_in,
   input  wire logic [1:0]     unit_in,
   // sense and select levels
   output frs_pkg::frs_drive_t drive
);
   // ----------------------------------------------------------------
   // head position, track zero after home_at steps, never if zero
   // ----------------------------------------------------------------
   logic [6:0] step_cnt_r;

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         step_cnt_r <= 7'h00;
      else if (step && step_cnt_r != 7'h7F)
         step_cnt_r <= step_cnt_r + 7'h01;
   end

   assign drive.write_prot = wp_in;
   assign drive.track_zero = (home_at != 7'h00) && (step_cnt_r >= home_at);
   assign drive.side_sel   = side_in;
   assign drive.unit_sel   = unit_in;
endmodule

// ===== frs_status_tb_top.sv
// self-checking bench for the result status registers
`timescale 1ns/1ns
module frs_status_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                sys_clk = 1'b0;
   logic                resetn = 1'b0;
   logic                cmd_start = 1'b0;
   frs_pkg::frs_cmd_t   cmd_info = '0;
   logic                cmd_done = 1'b0;
   logic [1:0]          cmd_term = 2'h0;
   logic                head_sel = 1'b0;
   frs_pkg::frs_evt_t   evt = '0;
   frs_pkg::frs_drive_t drive;
   logic                data_rd = 1'b0;
   logic [7:0]          rd_data_r;
   logic                result_avail_r;
   logic                exec_busy_r;
   logic [6:0]          home_at = 7'h00;
   logic                wp_in = 1'b0;
   int                  num_errors = 0;
   int                  total_checks = 0;

   always #4 sys_clk = ~sys_clk;

   frs_status #(.SVC_CYCLES(8)) uut
   (
      .sys_clk(sys_clk), .resetn(resetn), .cmd_start(cmd_start), .cmd_info(cmd_info),
      .cmd_done(cmd_done), .cmd_term(cmd_term), .head_sel(head_sel), .evt(evt),
      .drive(drive), .data_rd(data_rd), .rd_data_r(rd_data_r),
      .result_avail_r(result_avail_r), .exec_busy_r(exec_busy_r)
   );

   frs_drive_model drv
   (
      .sys_clk(sys_clk), .resetn(resetn), .step(evt.step_pulse), .home_at(home_at),
      .wp_in(wp_in), .side_in(1'b1), .unit_in(2'h2), .drive(drive)
   );

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ev(input logic [23:0] e);
      @(posedge sys_clk);
      evt <= e;
      @(posedge sys_clk);
      evt <= '0;
   endtask

   task automatic start(input logic [11:0] info);
      @(posedge sys_clk);
      cmd_start <= 1'b1;
      cmd_info  <= info;
      @(posedge sys_clk);
      cmd_start <= 1'b0;
      #1;
      chk({7'h0, exec_busy_r}, 8'h01);
   endtask

   task automatic finish_cmd(input logic [1:0] term, input logic head);
      int n;
      @(posedge sys_clk);
      cmd_done <= 1'b1;
      cmd_term <= term;
      head_sel <= head;
      @(posedge sys_clk);
      cmd_done <= 1'b0;
      n = 0;
      #1;
      while (result_avail_r !== 1'b1 && n < 20)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n == 20)
      begin
         num_errors++;
         tally_and_finish();
      end
      else
         chk({7'h0, exec_busy_r}, 8'h00);
   endtask

   // host reads the four result bytes in order
   task automatic read4(input logic [31:0] exp);
      for (int i = 0; i < 4; i++)
      begin
         chk(rd_data_r, exp[31-8*i -: 8]);
         @(posedge sys_clk);
         data_rd <= 1'b1;
         @(posedge sys_clk);
         data_rd <= 1'b0;
         #1;
      end
      chk({7'h0, result_avail_r}, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge sys_clk);
      resetn  <= 1'b1;
      home_at <= 7'h01;
      #1;
      chk(rd_data_r, 8'h00);
      chk({6'h0, result_avail_r, exec_busy_r}, 8'h00);
      // invalid command from idle, idle events ignored, track zero shown
      ev(24'h100004);
      finish_cmd(2'h2, 1'b0);
      read4(32'h82000036);
      @(posedge sys_clk);
      home_at <= 7'h00;
      // read with end of cylinder, data crc, byte served in time
      start(12'h405);
      ev(24'h500000);
      ev(24'h000002);
      ev(24'h000001);
      finish_cmd(2'h0, 1'b1);
      read4(32'h06A02026);
      // scan with id crc, deleted and missing data marks, cylinder FF
      start(12'h605);
      ev(24'h20F000);
      ev(24'h000FF8);
      finish_cmd(2'h1, 1'b0);
      read4(32'h42255F26);
      // protected write with seek end, missing id mark and overrun
      @(posedge sys_clk);
      wp_in <= 1'b1;
      start(12'h805);
      ev(24'h850000);
      ev(24'h000002);
      repeat (12) @(posedge sys_clk);
      finish_cmd(2'h0, 1'b0);
      read4(32'h2217006E);
      // recalibrate that never reaches track zero
      @(posedge sys_clk);
      wp_in <= 1'b0;
      start(12'h100);
      repeat (77) ev(24'h000004);
      ev(24'h020000);
      finish_cmd(2'h1, 1'b0);
      read4(32'h52040026);
      tally_and_finish();
   end
endmodule
